// >>> include/idioe_regs.svh
// Purpose: register offsets, field positions, codes and reset values of the
//          isolated digital I/O event block.
// Assumes: 32-bit register words at byte addresses, 8-bit address.
// Notes:   definitions only.
`ifndef IDIOE_REGS_SVH
`define IDIOE_REGS_SVH

`define IDIOE_ADDR_W        8
`define IDIOE_DATA_W        32

// register byte offsets
`define IDIOE_OFF_INPUT     8'h00
`define IDIOE_OFF_OUTPUT    8'h04
`define IDIOE_OFF_EVMASK1   8'h08
`define IDIOE_OFF_EVMASK2   8'h0C
`define IDIOE_OFF_CTRL      8'h10
`define IDIOE_OFF_IRQSTAT   8'h14
`define IDIOE_OFF_IRQEN     8'h18
`define IDIOE_OFF_DIAG      8'h1C
`define IDIOE_OFF_CTRSIG    8'h20

// event mask codes, three bits per input
`define IDIOE_CODE_LOW      3'h0
`define IDIOE_CODE_HIGH     3'h1
`define IDIOE_CODE_FALL     3'h2
`define IDIOE_CODE_RISE     3'h3
`define IDIOE_CODE_BOTH     3'h4
`define IDIOE_CODE_UNUSED   3'h7

// control register bits
`define IDIOE_CTRL_P1EN     0
`define IDIOE_CTRL_P1AND    1
`define IDIOE_CTRL_P2EN     2
`define IDIOE_CTRL_WDEN     3
`define IDIOE_CTRL_W        4

// pending / enable bits
`define IDIOE_IRQ_EV1       0
`define IDIOE_IRQ_EV2       1
`define IDIOE_IRQ_CT1       2
`define IDIOE_IRQ_CT2       3
`define IDIOE_IRQ_CT3       4
`define IDIOE_IRQ_WDOG      5
`define IDIOE_IRQ_SUPPLY    6
`define IDIOE_IRQ_FAULT     7
`define IDIOE_NUM_IRQ       8

// reset values
`define IDIOE_OUT_RST       16'h0000
`define IDIOE_MASK1_RST     24'hFF_FFFF
`define IDIOE_MASK2_RST     18'h3_FFFF
`define IDIOE_CTRL_RST      4'h0
`define IDIOE_IRQ_RST       8'h00

`endif

// >>> include/idioe_pkg.sv
// Purpose: types shared by the isolated digital I/O event block.
// Assumes: widths from idioe_regs.svh.
// Notes:   carrier structs for bus request, faults, counters and diagnostics.
`include "idioe_regs.svh"

package idioe_pkg;

  typedef struct packed {
    logic [`IDIOE_ADDR_W-1:0] addr;
    logic [`IDIOE_DATA_W-1:0] wdata;
    logic                     wr;
    logic                     rd;
  } idioe_busreq_t;

  typedef struct packed {
    logic [3:0] overTemp;
    logic       shortCircuit;
    logic       supplyLow;
  } idioe_fault_t;

  typedef struct packed {
    logic c1Sig;
    logic c2Sig;
    logic c2Trig;
    logic c2Gate;
    logic c3Sig;
    logic c3Gate;
  } idioe_ctr_t;

  typedef struct packed {
    logic faultDiag;
    logic supplyDiag;
  } idioe_diag_t;

endpackage : idioe_pkg

// >>> hdl/idioe_port_event.sv
// Purpose: pattern event detector for one input port.
// Assumes: inCur/inPrev are registered samples one cycle apart.
// Notes:   evPulse is one cycle wide, on the unfulfilled-to-fulfilled step.
`timescale 1ns/1ps
`default_nettype none
`include "idioe_regs.svh"

module idioe_port_event #(
  parameter int N         = 8,
  parameter bit ALLOW_AND = 1'b1
) (
  // clock and reset
  input  wire logic           mclk,
  input  wire logic           resetn,
  // samples and configuration
  input  wire logic [N-1:0]   inCur,
  input  wire logic [N-1:0]   inPrev,
  input  wire logic [3*N-1:0] maskCodes,
  input  wire logic           enable,
  input  wire logic           andMode,
  // result
  output logic                evPulse
);

  if (N < 1 || N > 8) begin : g_chk
    $error("idioe_port_event: N must be 1..8");
  end

  function automatic logic condUsed(input logic [2:0] code);
    condUsed = (code <= `IDIOE_CODE_BOTH);
  endfunction : condUsed

  function automatic logic condHit(input logic [2:0] code, input logic cur, input logic prev);
    case (code)
      `IDIOE_CODE_LOW:  condHit = ~cur;
      `IDIOE_CODE_HIGH: condHit = cur;
      `IDIOE_CODE_FALL: condHit = prev & ~cur;
      `IDIOE_CODE_RISE: condHit = ~prev & cur;
      `IDIOE_CODE_BOTH: condHit = prev ^ cur;
      default:          condHit = 1'b0;
    endcase
  endfunction : condHit

  logic fulfilled;
  logic fulfilledPrev_r;
  logic fulfilledPrev_nxt;
  logic hitAll;
  logic hitAny;
  logic anyUsed;

  always_comb begin
    hitAll  = 1'b1;
    hitAny  = 1'b0;
    anyUsed = 1'b0;
    for (int i = 0; i < N; i++) begin
      if (condUsed(maskCodes[3*i +: 3])) begin
        anyUsed = 1'b1;
        if (condHit(maskCodes[3*i +: 3], inCur[i], inPrev[i])) begin
          hitAny = 1'b1;
        end else begin
          hitAll = 1'b0;
        end
      end
    end
    // port without conjunction support always falls back to disjunction
    if (ALLOW_AND && andMode) begin
      fulfilled = enable & anyUsed & hitAll;
    end else begin
      fulfilled = enable & anyUsed & hitAny;
    end
    fulfilledPrev_nxt = fulfilled;
    evPulse           = fulfilled & ~fulfilledPrev_r;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      fulfilledPrev_r <= 1'b0;
    end else begin
      fulfilledPrev_r <= fulfilledPrev_nxt;
    end
  end

endmodule : idioe_port_event

`default_nettype wire

// >>> hdl/idioe_top.sv
// Purpose: 16-in / 16-out isolated digital I/O with pattern events,
//          fault shutdown and a single combined interrupt line.
// Assumes: all field inputs already synchronous to mclk; counters live
//          outside and report run-down as one-cycle pulses.
// Notes:
//
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "idioe_regs.svh"

module idioe_top #(
  parameter int NUM_IN  = 16,
  parameter int NUM_OUT = 16
) (
  // clock and reset
  input  wire logic                        mclk,
  input  wire logic                        resetn,
  // register port
  input  wire idioe_pkg::idioe_busreq_t    busReq,
  output logic [`IDIOE_DATA_W-1:0]         rdata,
  // field side
  input  wire logic [NUM_IN-1:0]           din,
  input  wire idioe_pkg::idioe_fault_t     faults,
  output logic [NUM_OUT-1:0]               dout,
  // external counters
  input  wire logic [2:0]                  ctrRunDown,
  output idioe_pkg::idioe_ctr_t            ctrSig,
  // diagnostics and interrupt
  output idioe_pkg::idioe_diag_t           diag,
  output logic                             irq
);

  import idioe_pkg::*;

  if (NUM_IN != 16 || NUM_OUT != 16) begin : g_chk
    $error("idioe_top: pin mapping serves 16 inputs and 16 outputs only");
  end

  localparam int P1_N = 8;
  localparam int P2_N = 6;

  function automatic logic isWrite(input idioe_busreq_t req,
                                   input logic [`IDIOE_ADDR_W-1:0] off);
    isWrite = req.wr && (req.addr == off);
  endfunction : isWrite

  // registered state
  logic [NUM_IN-1:0]         inCur_r;
  logic [NUM_IN-1:0]         inPrev_r;
  logic [NUM_OUT-1:0]        outLatch_r;
  logic [3*P1_N-1:0]         mask1_r;
  logic [3*P2_N-1:0]         mask2_r;
  logic [`IDIOE_CTRL_W-1:0]  ctrl_r;
  logic [`IDIOE_NUM_IRQ-1:0] pend_r;
  logic [`IDIOE_NUM_IRQ-1:0] irqEn_r;
  logic [NUM_OUT-1:0]        dout_r;
  logic                      irq_r;
  idioe_diag_t               diag_r;
  idioe_ctr_t                ctr_r;
  logic [`IDIOE_DATA_W-1:0]  rdata_r;

  // next values
  logic [NUM_IN-1:0]         inCur_nxt;
  logic [NUM_IN-1:0]         inPrev_nxt;
  logic [NUM_OUT-1:0]        outLatch_nxt;
  logic [3*P1_N-1:0]         mask1_nxt;
  logic [3*P2_N-1:0]         mask2_nxt;
  logic [`IDIOE_CTRL_W-1:0]  ctrl_nxt;
  logic [`IDIOE_NUM_IRQ-1:0] pend_nxt;
  logic [`IDIOE_NUM_IRQ-1:0] irqEn_nxt;
  logic [NUM_OUT-1:0]        dout_nxt;
  logic                      irq_nxt;
  idioe_diag_t               diag_nxt;
  idioe_ctr_t                ctr_nxt;
  logic [`IDIOE_DATA_W-1:0]  rdata_nxt;

  // working signals
  logic                      ev1Pulse;
  logic                      ev2Pulse;
  logic                      wdTrip;
  logic                      faultAny;
  logic [`IDIOE_NUM_IRQ-1:0] pendSet;
  logic [`IDIOE_NUM_IRQ-1:0] pendClr;
  logic [NUM_OUT-1:0]        forceOff;

  // port one: inputs 1-8, conjunction allowed
  idioe_port_event #(
    .N         (P1_N),
    .ALLOW_AND (1'b1)
  ) u_port1 (
    .mclk      (mclk),
    .resetn    (resetn),
    .inCur     (inCur_r[7:0]),
    .inPrev    (inPrev_r[7:0]),
    .maskCodes (mask1_r),
    .enable    (ctrl_r[`IDIOE_CTRL_P1EN]),
    .andMode   (ctrl_r[`IDIOE_CTRL_P1AND]),
    .evPulse   (ev1Pulse)
  );

  // port two: inputs 9-14, disjunction only; inputs 15-16 never reach it
  idioe_port_event #(
    .N         (P2_N),
    .ALLOW_AND (1'b0)
  ) u_port2 (
    .mclk      (mclk),
    .resetn    (resetn),
    .inCur     (inCur_r[13:8]),
    .inPrev    (inPrev_r[13:8]),
    .maskCodes (mask2_r),
    .enable    (ctrl_r[`IDIOE_CTRL_P2EN]),
    .andMode   (1'b0),
    .evPulse   (ev2Pulse)
  );

  always_comb begin
    // input sampling runs from reset with no setup needed
    inCur_nxt  = din;
    inPrev_nxt = inCur_r;

    // counter signal routing
    ctr_nxt.c1Sig  = din[13];
    ctr_nxt.c2Sig  = din[9];
    ctr_nxt.c2Trig = din[10];
    ctr_nxt.c2Gate = din[11];
    ctr_nxt.c3Sig  = din[14];
    ctr_nxt.c3Gate = din[15];
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      inCur_r  <= '0;
      inPrev_r <= '0;
      ctr_r    <= '0;
    end else begin
      inCur_r  <= inCur_nxt;
      inPrev_r <= inPrev_nxt;
      ctr_r    <= ctr_nxt;
    end
  end

  // fault decode shared by the output and interrupt groups
  always_comb begin
    wdTrip   = ctrRunDown[2] & ctrl_r[`IDIOE_CTRL_WDEN];
    faultAny = faults.shortCircuit | (|faults.overTemp);
  end

  // configuration writes
  always_comb begin
    mask1_nxt = mask1_r;
    if (isWrite(busReq, `IDIOE_OFF_EVMASK1)) begin
      mask1_nxt = busReq.wdata[3*P1_N-1:0];
    end
    mask2_nxt = mask2_r;
    if (isWrite(busReq, `IDIOE_OFF_EVMASK2)) begin
      mask2_nxt = busReq.wdata[3*P2_N-1:0];
    end
    ctrl_nxt = ctrl_r;
    if (isWrite(busReq, `IDIOE_OFF_CTRL)) begin
      ctrl_nxt = busReq.wdata[`IDIOE_CTRL_W-1:0];
    end
    irqEn_nxt = irqEn_r;
    if (isWrite(busReq, `IDIOE_OFF_IRQEN)) begin
      irqEn_nxt = busReq.wdata[`IDIOE_NUM_IRQ-1:0];
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      mask1_r <= `IDIOE_MASK1_RST;
      mask2_r <= `IDIOE_MASK2_RST;
      ctrl_r  <= `IDIOE_CTRL_RST;
      irqEn_r <= `IDIOE_IRQ_RST;
    end else begin
      mask1_r <= mask1_nxt;
      mask2_r <= mask2_nxt;
      ctrl_r  <= ctrl_nxt;
      irqEn_r <= irqEn_nxt;
    end
  end

  // output latch; watchdog clears it so software must switch on again
  always_comb begin
    outLatch_nxt = outLatch_r;
    if (wdTrip) begin
      outLatch_nxt = `IDIOE_OUT_RST;
    end else if (isWrite(busReq, `IDIOE_OFF_OUTPUT)) begin
      outLatch_nxt = busReq.wdata[NUM_OUT-1:0];
    end

    // overheat and supply-low shutdown override the latch but leave it intact for recovery
    forceOff = {{4{faults.overTemp[3]}}, {4{faults.overTemp[2]}},
                {4{faults.overTemp[1]}}, {4{faults.overTemp[0]}}};
    if (faults.supplyLow || wdTrip) begin
      forceOff = {NUM_OUT{1'b1}};
    end
    dout_nxt = outLatch_r & ~forceOff;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      outLatch_r <= `IDIOE_OUT_RST;
      dout_r     <= `IDIOE_OUT_RST;
    end else begin
      outLatch_r <= outLatch_nxt;
      dout_r     <= dout_nxt;
    end
  end

  // sticky sources; level faults keep re-setting while present
  always_comb begin
    pendSet                     = '0;
    pendSet[`IDIOE_IRQ_EV1]     = ev1Pulse;
    pendSet[`IDIOE_IRQ_EV2]     = ev2Pulse;
    pendSet[`IDIOE_IRQ_CT1]     = ctrRunDown[0];
    pendSet[`IDIOE_IRQ_CT2]     = ctrRunDown[1];
    pendSet[`IDIOE_IRQ_CT3]     = ctrRunDown[2];
    pendSet[`IDIOE_IRQ_WDOG]    = wdTrip;
    pendSet[`IDIOE_IRQ_SUPPLY]  = faults.supplyLow;
    pendSet[`IDIOE_IRQ_FAULT]   = faultAny;
    pendClr = '0;
    if (isWrite(busReq, `IDIOE_OFF_IRQSTAT)) begin
      pendClr = busReq.wdata[`IDIOE_NUM_IRQ-1:0];
    end
    // set wins over a same-cycle clear
    pend_nxt = (pend_r & ~pendClr) | pendSet;
    irq_nxt  = |(pend_nxt & irqEn_nxt);

    diag_nxt.faultDiag  = faultAny;
    diag_nxt.supplyDiag = faults.supplyLow;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pend_r <= `IDIOE_IRQ_RST;
      irq_r  <= 1'b0;
      diag_r <= '0;
    end else begin
      pend_r <= pend_nxt;
      irq_r  <= irq_nxt;
      diag_r <= diag_nxt;
    end
  end

  // read data valid only in the cycle after the strobe
  always_comb begin
    rdata_nxt = '0;
    if (busReq.rd) begin
      case (busReq.addr)
        `IDIOE_OFF_INPUT:   rdata_nxt[NUM_IN-1:0]         = inCur_r;
        `IDIOE_OFF_OUTPUT:  rdata_nxt[NUM_OUT-1:0]        = outLatch_r;
        `IDIOE_OFF_EVMASK1: rdata_nxt[3*P1_N-1:0]         = mask1_r;
        `IDIOE_OFF_EVMASK2: rdata_nxt[3*P2_N-1:0]         = mask2_r;
        `IDIOE_OFF_CTRL:    rdata_nxt[`IDIOE_CTRL_W-1:0]  = ctrl_r;
        `IDIOE_OFF_IRQSTAT: rdata_nxt[`IDIOE_NUM_IRQ-1:0] = pend_r;
        `IDIOE_OFF_IRQEN:   rdata_nxt[`IDIOE_NUM_IRQ-1:0] = irqEn_r;
        `IDIOE_OFF_DIAG: begin
          rdata_nxt[0]   = diag_r.faultDiag;
          rdata_nxt[1]   = diag_r.supplyDiag;
          rdata_nxt[7:4] = faults.overTemp;
        end
        `IDIOE_OFF_CTRSIG:  rdata_nxt[5:0]                = ctr_r;
        default:            rdata_nxt                     = '0;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata  = rdata_r;
  assign dout   = dout_r;
  assign irq    = irq_r;
  assign diag   = diag_r;
  assign ctrSig = ctr_r;

endmodule : idioe_top

`default_nettype wire

// >>> sim/idioe_checker.sv
// Purpose: port-level assertions for the digital I/O event block.
// Assumes: register map and latencies as handed over with the design.
// Notes:   bound into idioe_top; sees its ports only.
`timescale 1ns/1ps
`default_nettype none

module idioe_checker #(
  parameter int NUM_IN  = 16,
  parameter int NUM_OUT = 16
) (
  // clock and reset
  input wire logic                     mclk,
  input wire logic                     resetn,
  // register port
  input wire idioe_pkg::idioe_busreq_t busReq,
  input wire logic [31:0]              rdata,
  // field side
  input wire logic [NUM_IN-1:0]        din,
  input wire idioe_pkg::idioe_fault_t  faults,
  input wire logic [NUM_OUT-1:0]       dout,
  input wire logic [2:0]               ctrRunDown,
  input wire idioe_pkg::idioe_ctr_t    ctrSig,
  input wire idioe_pkg::idioe_diag_t   diag,
  input wire logic                     irq
);
  import idioe_pkg::*;
  logic [1:0]         upR;
  logic [NUM_OUT-1:0] otMask;
  logic               quiet;
  // $past is only trusted two edges after reset
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) upR <= 2'h0;
    else upR <= {upR[0], 1'b1};
  end
  always_comb begin
    otMask = {{4{faults.overTemp[3]}}, {4{faults.overTemp[2]}},
              {4{faults.overTemp[1]}}, {4{faults.overTemp[0]}}};
    quiet  = faults == '0 && !ctrRunDown[2];
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);

  AST_RESET_OFF: assert property (!upR[0] |-> dout == 16'h0000 && !irq)
    else $error("outputs or irq not quiet after reset");
  AST_OUT_WRITE: assert property (quiet ##1 busReq.wr && busReq.addr == 8'h04 && quiet
    ##1 quiet |=> dout == $past(busReq.wdata[15:0], 2))
    else $error("output write not seen on dout");
  AST_IN_READ: assert property (upR[1] && busReq.rd && busReq.addr == 8'h00
    |=> rdata == {16'h0000, $past(din, 2)})
    else $error("input read data wrong");
  AST_GROUP_OFF: assert property ((dout & $past(otMask)) == 16'h0000)
    else $error("overheated group still driven");
  AST_SUPPLY_OFF: assert property (faults.supplyLow |=> dout == 16'h0000)
    else $error("outputs on with supply low");
  AST_FAULT_DIAG: assert property (upR[1] |->
    diag.faultDiag == $past(faults.shortCircuit || faults.overTemp != 4'h0))
    else $error("fault diagnostic wrong");
  AST_SUPPLY_DIAG: assert property (upR[1] |-> diag.supplyDiag == $past(faults.supplyLow))
    else $error("supply diagnostic wrong");
  AST_CTR_ROUTE: assert property (upR[1] |->
    ctrSig == $past({din[13], din[9], din[10], din[11], din[14], din[15]}))
    else $error("counter inputs misrouted");

  cover property (faults.supplyLow ##1 dout == 16'h0000);
  cover property (ctrRunDown[2] ##2 dout == 16'h0000);
  cover property ($rose(irq));
endmodule : idioe_checker

bind idioe_top idioe_checker #(.NUM_IN(NUM_IN), .NUM_OUT(NUM_OUT)) idioe_checker_i (
  .mclk, .resetn, .busReq, .rdata, .din, .faults, .dout, .ctrRunDown, .ctrSig, .diag, .irq);

`default_nettype wire

// >>> sim/idioe_field_model.sv
// Purpose: field sensors and loads on the isolated side.
// Assumes: sensors settle one mclk cycle after the bench asks.
// Notes:   a shorted load only reports while some output drives it.
`timescale 1ns/1ps
`default_nettype none

module idioe_field_model (
  // clock
  input wire logic                     mclk,
  // bench requests
  input wire logic [15:0]              sense,
  input wire logic [3:0]               heat,
  input wire logic                     dip,
  input wire logic                     shortReq,
  // load side
  input wire logic [15:0]              dout,
  output logic [15:0]                  din,
  output idioe_pkg::idioe_fault_t      faults
);
  import idioe_pkg::*;
  logic [15:0] senseR = 16'h0000;
  always @(posedge mclk) senseR <= sense;
  assign din    = senseR;
  assign faults = '{overTemp: heat, shortCircuit: shortReq && dout != 16'h0000,
                    supplyLow: dip};
endmodule : idioe_field_model

`default_nettype wire

// >>> sim/tb_top.sv
// Purpose: self-checking bench for the digital I/O event block.
// Assumes: register offsets and codes as handed over with the design.
// Notes:   random outputs and inputs from a fixed seed, corner cases by hand.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import idioe_pkg::*;
  logic          mclk = 1'b0, resetn = 1'b0, dip = 1'b0, shortReq = 1'b0;
  idioe_busreq_t busReq = '0;
  logic [31:0]   rdata, d;
  logic [15:0]   din, dout, sense = 16'h0000;
  logic [3:0]    heat = 4'h0;
  logic [2:0]    ctrRunDown = 3'h0;
  idioe_fault_t  faults;
  idioe_ctr_t    ctrSig;
  idioe_diag_t   diag;
  logic          irq;
  int            n_fail = 0, num_checks = 0, cyc = 0, seed = 32'h349a, i;
  logic [7:0]    ra[7] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h3C};
  logic [31:0]   rv[7] = '{32'h0000_0000, 32'h00FF_FFFF, 32'h0003_FFFF, 32'h0000_0000,
                           32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
  logic          st[5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};

  idioe_top idioe_top_i (.mclk, .resetn, .busReq, .rdata, .din, .faults, .dout,
    .ctrRunDown, .ctrSig, .diag, .irq);
  idioe_field_model idioe_field_model_i (.mclk, .sense, .heat, .dip, .shortReq,
    .dout, .din, .faults);

  always #2.5 mclk = ~mclk;

  function automatic logic [31:0] ctrExp(input logic [15:0] v);
    return {26'h0, v[13], v[9], v[10], v[11], v[14], v[15]};
  endfunction : ctrExp
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk) busReq <= '{a, v, 1'b1, 1'b0};
    @(posedge mclk) busReq.wr <= 1'b0;
  endtask : wr
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk) busReq <= '{a, 32'h0000_0000, 1'b0, 1'b1};
    @(posedge mclk) busReq.rd <= 1'b0;
    #1 chk(nm, rdata, e);
  endtask : rdchk
  task automatic clr;
    wr(8'h14, 32'h0000_00FF);
  endtask : clr

  // hang guard, generous against a run of under a thousand cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      final_report;
    end
  end

  initial begin
    repeat (16) @(posedge mclk);
    resetn <= 1'b1;
    #1 chk("doutRst", dout, 32'h0000_0000);
    for (i = 0; i < 7; i++) rdchk("regRst", ra[i], rv[i]);
    for (i = 0; i < 8; i++) begin
      sense <= $random(seed);
      d = $random(seed);
      wr(8'h04, d);
      tick(2);
      #1 chk("dout", dout, d[15:0]);
      rdchk("outReg", 8'h04, d[15:0]);
      rdchk("inReg", 8'h00, sense);
      rdchk("ctrReg", 8'h20, ctrExp(sense));
    end
    wr(8'h04, 32'h0000_FFFF);
    for (i = 0; i < 4; i++) begin
      heat <= 4'h1 << i;
      tick(3);
      #1 chk("grpOff", dout, 16'hFFFF & ~(16'h000F << 4 * i));
      chk("faultDiag", diag.faultDiag, 1'b1);
      rdchk("diagReg", 8'h1C, 32'h0000_0001 | (32'h0000_0010 << i));
      heat <= 4'h0;
      tick(3);
      #1 chk("grpBack", dout, 16'hFFFF);
    end
    wr(8'h18, 32'h0000_00C0);
    dip <= 1'b1;
    tick(3);
    #1 chk("supplyOff", dout, 16'h0000);
    chk("supplyDiag", diag.supplyDiag, 1'b1);
    chk("irqSupply", irq, 1'b1);
    dip <= 1'b0;
    tick(2);
    clr;
    tick(2);
    #1 chk("irqClr", irq, 1'b0);
    shortReq <= 1'b1;
    tick(3);
    rdchk("stShort", 8'h14, 32'h0000_0080);
    shortReq <= 1'b0;
    tick(2);
    clr;
    // each code: start where it is unmet, then make the one change it wants
    wr(8'h18, 32'h0000_0003);
    wr(8'h10, 32'h0000_0001);
    for (i = 0; i < 5; i++) begin
      sense[0] <= st[i];
      wr(8'h08, 32'h00FF_FFF8 | i);
      tick(3);
      clr;
      tick(2);
      sense[0] <= ~st[i];
      tick(4);
      #1 chk("irqEv", irq, 1'b1);
      rdchk("code", 8'h14, 32'h0000_0001);
      clr;
    end
    sense[1:0] <= 2'b00;
    wr(8'h08, 32'h00FF_FFC9);
    tick(3);
    clr;
    sense[0] <= 1'b1;
    tick(4);
    rdchk("orFirst", 8'h14, 32'h0000_0001);
    clr;
    sense[15:1] <= ~sense[15:1];
    tick(4);
    rdchk("orNoRepeat", 8'h14, 32'h0000_0000);
    wr(8'h10, 32'h0000_0003);
    sense[1:0] <= 2'b11;
    wr(8'h08, 32'h00FF_FFC1);
    tick(3);
    clr;
    tick(4);
    rdchk("andPart", 8'h14, 32'h0000_0000);
    sense[1] <= 1'b0;
    tick(4);
    rdchk("andAll", 8'h14, 32'h0000_0001);
    wr(8'h10, 32'h0000_0006);
    sense[9:8] <= 2'b00;
    wr(8'h0C, 32'h0003_FFC9);
    tick(3);
    clr;
    sense[8] <= 1'b1;
    tick(4);
    rdchk("p2Or", 8'h14, 32'h0000_0002);
    wr(8'h04, 32'h0000_FFFF);
    wr(8'h10, 32'h0000_0008);
    tick(2);
    clr;
    ctrRunDown <= 3'h7;
    tick(1);
    ctrRunDown <= 3'h0;
    tick(3);
    #1 chk("wdogOff", dout, 16'h0000);
    rdchk("ctrSrc", 8'h14, 32'h0000_003C);
    final_report;
  end
endmodule : tb_top

`default_nettype wire
